// ### osw_ctrl.sv
// Oscillation stabilization wait controller with low-speed oscillator control.
`timescale 1ns/1ps
`default_nettype none
module osw_ctrl
   import osw_pkg::*;
#(
   parameter logic [16:0] WAIT_CNT_C1 = 17'h00800,
   parameter logic [16:0] WAIT_CNT_C2 = 17'h02000,
   parameter logic [16:0] WAIT_CNT_C3 = 17'h04000,
   parameter logic [16:0] WAIT_CNT_C4 = 17'h08000,
   parameter logic [16:0] WAIT_CNT_C5 = 17'h10000
)(
   // Clock and reset.
   input  wire logic        clock,
   input  wire logic        rst_n,
   // CPU memory access port.
   input  wire logic [15:0] mem_addr,
   input  wire logic [7:0]  mem_wdata,
   input  wire logic        mem_wr,
   input  wire logic        mem_rd,
   input  wire logic        mem_bit_op,
   output logic      [7:0]  mem_rdata,
   // Stop state and CPU clock path.
   input  wire logic        stop_mode,
   input  wire logic        cpu_clk_is_main,
   input  wire logic        main_crystal_osc_running,
   output logic             cpu_hold,
   output logic             stab_done,
   output logic      [4:0]  stabilization_status,
   // Low-speed oscillator.
   input  wire logic        ls_stop_allowed,
   input  wire logic        ls_stop_req,
   output logic             ls_osc_run,
   output logic             ls_tick,
   output logic             ls_tick_div8,
   output logic             ls_tick_div128,
   output logic             ls_tick_div512
);
   logic [2:0]      sel_ff;
   logic [16:0]     cnt_ff;
   logic [4:0]      status_ff;
   logic [7:0]      rdata_ff;
   logic            osc_meta_ff;
   logic            osc_ok_ff;
   logic            ls_stop_ff;
   logic            done_ff;
   osw_state_type   state_ff;
   osw_state_type   nxt_state;
   logic [16:0]     nxt_cnt;
   logic [16:0]     limit;
   logic [16:0]     cnt_inc;
   logic            hit;
   logic            wr_sel;
   logic            rd_sel;
   logic            reach;
   logic [16:0]     thresh [5];
   logic [4:0]      nxt_status;
   osw_ls_if        ls_bus ();

   // Unused and prohibited codes fall back to the longest wait.
   function automatic logic [16:0] wait_limit(input logic [2:0] code);
      logic [16:0] r;
      r = WAIT_CNT_C5;
      if (code == CODE_W11) r = WAIT_CNT_C1;
      else if (code == CODE_W13) r = WAIT_CNT_C2;
      else if (code == CODE_W14) r = WAIT_CNT_C3;
      else if (code == CODE_W15) r = WAIT_CNT_C4;
      return r;
   endfunction

   assign hit     = (mem_addr == OFF_WAIT_SEL);
   // (RULE_04) byte access only
   assign wr_sel  = hit && mem_wr && !mem_bit_op;
   assign rd_sel  = hit && mem_rd && !mem_bit_op;
   // (RULE_02) wait code decode
   assign limit   = wait_limit(sel_ff);
   assign cnt_inc = cnt_ff + 17'h00001;
   assign reach   = (cnt_inc >= limit);

   assign thresh[0] = WAIT_CNT_C1;
   assign thresh[1] = WAIT_CNT_C2;
   assign thresh[2] = WAIT_CNT_C3;
   assign thresh[3] = WAIT_CNT_C4;
   assign thresh[4] = WAIT_CNT_C5;

   // (RULE_07) status never passes selected wait
   for (genvar i = 0; i < 5; i++) begin : g_status
      assign nxt_status[i] = (nxt_cnt >= thresh[i]);
   end

   // (RULE_03) reset value and zero upper bits
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sel_ff   <= WAIT_SEL_RST;
         rdata_ff <= 8'h00;
      end else begin
         if (wr_sel) sel_ff <= mem_wdata[2:0];
         if (rd_sel) rdata_ff <= {5'h00, sel_ff};
      end
   end

   // (RULE_09) crystal running, two-stage synchroniser
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         osc_meta_ff <= 1'b0;
         osc_ok_ff   <= 1'b0;
      end else begin
         osc_meta_ff <= main_crystal_osc_running;
         osc_ok_ff   <= osc_meta_ff;
      end
   end

   // (RULE_13) stabilization sequencing
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      case (state_ff)
         ST_IDLE, ST_DONE: begin
            if (stop_mode) begin
               nxt_state = ST_STOPPED;
               nxt_cnt   = CNT_RST;
            end else if (cnt_ff > limit) begin
               // A shorter wait written after completion also caps the reported steps.
               nxt_cnt = limit;
            end
         end
         ST_STOPPED: begin
            nxt_cnt = CNT_RST;
            if (!stop_mode) nxt_state = ST_WAIT_OSC;
         end
         ST_WAIT_OSC: begin
            if (stop_mode) nxt_state = ST_STOPPED;
            else if (osc_ok_ff) nxt_state = ST_COUNT;
         end
         ST_COUNT: begin
            if (stop_mode) begin
               nxt_state = ST_STOPPED;
               nxt_cnt   = CNT_RST;
            end else begin
               nxt_cnt = reach ? limit : cnt_inc;
               if (reach) nxt_state = ST_DONE;
            end
         end
         default: nxt_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_ff  <= ST_IDLE;
         cnt_ff    <= CNT_RST;
         status_ff <= 5'h00;
         done_ff   <= 1'b0;
      end else begin
         state_ff  <= nxt_state;
         cnt_ff    <= nxt_cnt;
         status_ff <= nxt_status;
         done_ff   <= (nxt_state == ST_DONE);
      end
   end

   // (RULE_01) CPU held during the wait
   assign cpu_hold = cpu_clk_is_main && ((state_ff == ST_WAIT_OSC) || (state_ff == ST_COUNT));

   // (RULE_11) stop only when option allows
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) ls_stop_ff <= 1'b0;
      else ls_stop_ff <= ls_stop_req && ls_stop_allowed;
   end

   // (RULE_10) runs from reset release
   assign ls_bus.run = !ls_stop_ff;

   osw_lsdiv u_lsdiv (
      .clock (clock),
      .rst_n (rst_n),
      .ls    (ls_bus)
   );

   assign mem_rdata            = rdata_ff;
   assign stab_done            = done_ff;
   assign stabilization_status = status_ff;
   assign ls_osc_run           = ls_bus.run;
   assign ls_tick              = ls_bus.tick;
   assign ls_tick_div8         = ls_bus.tick_div8;
   assign ls_tick_div128       = ls_bus.tick_div128;
   assign ls_tick_div512       = ls_bus.tick_div512;

   sequence s_last_step;
      state_ff == ST_COUNT && !stop_mode && cnt_inc == limit;
   endsequence
   sequence s_finished;
      ##1 state_ff == ST_DONE && cnt_ff == limit && stab_done;
   endsequence

   property p_hold;
      @(posedge clock) disable iff (!rst_n)
         (state_ff == ST_COUNT) && cpu_clk_is_main |-> cpu_hold;
   endproperty
   a_hold: assert property (p_hold) else $error("CPU not held during wait"); // RULE_01

   property p_code1;
      @(posedge clock) disable iff (!rst_n) sel_ff == CODE_W11 |-> limit == WAIT_CNT_C1;
   endproperty
   a_code1: assert property (p_code1) else $error("wrong limit for shortest code"); // RULE_02

   property p_sel_rst;
      @(posedge clock) disable iff (!rst_n) $rose(rst_n) |-> sel_ff == WAIT_SEL_RST;
   endproperty
   a_sel_rst: assert property (p_sel_rst) else $error("wait select reset wrong"); // RULE_03

   property p_upper_zero;
      @(posedge clock) disable iff (!rst_n) rd_sel |=> mem_rdata == {5'h00, $past(sel_ff)};
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper bits not zero"); // RULE_03

   property p_bit_ignored;
      @(posedge clock) disable iff (!rst_n) hit && mem_wr && mem_bit_op |=> $stable(sel_ff);
   endproperty
   a_bit_ignored: assert property (p_bit_ignored) else $error("bit write changed select"); // RULE_04

   property p_cnt_limit;
      @(posedge clock) disable iff (!rst_n) $stable(sel_ff) |-> cnt_ff <= limit;
   endproperty
   a_cnt_limit: assert property (p_cnt_limit) else $error("counter passed limit"); // RULE_07

   property p_no_osc;
      @(posedge clock) disable iff (!rst_n)
         state_ff == ST_WAIT_OSC && !osc_ok_ff |=> cnt_ff == CNT_RST;
   endproperty
   a_no_osc: assert property (p_no_osc) else $error("counted before oscillation"); // RULE_09

   property p_ls_run;
      @(posedge clock) disable iff (!rst_n) !ls_stop_allowed |=> ls_osc_run;
   endproperty
   a_ls_run: assert property (p_ls_run) else $error("low-speed stopped illegally"); // RULE_11

   property p_ls_stop;
      @(posedge clock) disable iff (!rst_n) ls_stop_req && ls_stop_allowed |=> !ls_osc_run;
   endproperty
   a_ls_stop: assert property (p_ls_stop) else $error("low-speed stop ignored"); // RULE_11

   property p_stop_clear;
      @(posedge clock) disable iff (!rst_n) stop_mode |=> cnt_ff == CNT_RST;
   endproperty
   a_stop_clear: assert property (p_stop_clear) else $error("counter not cleared"); // RULE_13

   property p_done;
      @(posedge clock) disable iff (!rst_n) s_last_step |-> s_finished;
   endproperty
   a_done: assert property (p_done) else $error("completion not flagged"); // RULE_13
endmodule
`default_nettype wire

// ### osw_ls_if.sv
// Interface carrying the low-speed clock enables between divider and controller.
`timescale 1ns/1ps
`default_nettype none
interface osw_ls_if;
   logic run;
   logic tick;
   logic tick_div8;
   logic tick_div128;
   logic tick_div512;
   modport src (input run, output tick, output tick_div8, output tick_div128, output tick_div512);
   modport snk (output run, input tick, input tick_div8, input tick_div128, input tick_div512);
endinterface
`default_nettype wire

// ### osw_lsdiv.sv
// Low-speed oscillator emulated as enable pulses divided down from the main clock.
`timescale 1ns/1ps
`default_nettype none
module osw_lsdiv
   import osw_pkg::*;
(
   // Clock and reset.
   input  wire logic clock,
   input  wire logic rst_n,
   // Enables toward the controller.
   osw_ls_if.src     ls
);
   logic [7:0] base_ff;
   logic [8:0] sub_ff;
   logic       base_end;
   logic [8:0] nxt_sub;

   assign base_end = (base_ff == 8'(LS_DIV_CYC - 1));
   assign nxt_sub  = sub_ff + 9'h001;

   // (RULE_12) low-speed enable taps
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         base_ff        <= 8'h00;
         sub_ff         <= 9'h000;
         ls.tick        <= 1'b0;
         ls.tick_div8   <= 1'b0;
         ls.tick_div128 <= 1'b0;
         ls.tick_div512 <= 1'b0;
      end else begin
         base_ff        <= (!ls.run || base_end) ? 8'h00 : base_ff + 8'h01;
         sub_ff         <= !ls.run ? 9'h000 : (base_end ? nxt_sub : sub_ff);
         ls.tick        <= ls.run && base_end;
         ls.tick_div8   <= ls.run && base_end && (nxt_sub[2:0] == 3'(LS_DIV8_CYC % 8));
         ls.tick_div128 <= ls.run && base_end && (nxt_sub[6:0] == 7'(LS_DIV128_CYC % 128));
         ls.tick_div512 <= ls.run && base_end && (nxt_sub == 9'(LS_DIV512_CYC % 512));
      end
   end

   property p_div_sub;
      @(posedge clock) disable iff (!rst_n) ls.tick_div8 |-> ls.tick;
   endproperty
   a_div_sub: assert property (p_div_sub) else $error("divided tick without base tick"); // RULE_12

   property p_stopped_quiet;
      @(posedge clock) disable iff (!rst_n) !ls.run ##1 !ls.run |-> !ls.tick;
   endproperty
   a_stopped_quiet: assert property (p_stopped_quiet) else $error("tick while stopped"); // RULE_11
endmodule
`default_nettype wire

// ### osw_pkg.sv
// Constants and types shared by the oscillation stabilization wait controller.
// Contract
// (RULE_01) With main crystal as CPU clock, hold CPU after stop release until wait elapses.
// (RULE_02) Wait codes one to five select 2^11, 2^13, 2^14, 2^15, 2^16 periods.
// (RULE_03) Wait select resets to five; its upper five bits read zero.
// (RULE_04) Wait select is written and read only as a whole byte.
// (RULE_05) Software leaves wait select alone while a stabilization wait runs.
// (RULE_06) Software sets wait select before entering stop with the crystal clocking the CPU.
// (RULE_07) Stabilization counter stops at the selected wait; status never passes it.
// (RULE_08) With internal clock, software polls status for no more than the selected wait.
// (RULE_09) Counting starts only once the crystal really oscillates.
// (RULE_10) Low-speed oscillator runs from reset release without software action.
// (RULE_11) Software may stop the low-speed oscillator only if the option byte allows.
// (RULE_12) Low-speed clock never clocks the CPU; feeds watchdog, timer, display ticks.
// (RULE_13) Counter clears on stop entry, counts per cycle after release, flags completion.
package osw_pkg;
   localparam logic [15:0] OFF_WAIT_SEL  = 16'hffa4;
   localparam logic [2:0]  WAIT_SEL_RST  = 3'h5;
   localparam logic [2:0]  CODE_W11      = 3'h1;
   localparam logic [2:0]  CODE_W13      = 3'h2;
   localparam logic [2:0]  CODE_W14      = 3'h3;
   localparam logic [2:0]  CODE_W15      = 3'h4;
   localparam logic [2:0]  CODE_W16      = 3'h5;
   localparam int          CNT_W         = 17;
   localparam logic [16:0] CNT_RST       = 17'h00000;
   localparam int          CLK_FREQ_KHZ  = 40000;
   localparam int          LS_FREQ_KHZ   = 240;
   localparam int          LS_DIV_CYC    = CLK_FREQ_KHZ / LS_FREQ_KHZ;
   localparam int          LS_DIV8_CYC   = 8;
   localparam int          LS_DIV128_CYC = 128;
   localparam int          LS_DIV512_CYC = 512;
   typedef enum logic [2:0] {ST_IDLE, ST_STOPPED, ST_WAIT_OSC, ST_COUNT, ST_DONE} osw_state_type;
endpackage

// ### osw_xtal_model.sv
// Behavioural main crystal that falls silent in stop and restarts after a start-up delay.
`timescale 1ns/1ps
`default_nettype none
module osw_xtal_model #(
   parameter int START_CYC = 10
)(
   // Clock and reset.
   input  wire logic clock,
   input  wire logic rst_n,
   // Stop state from the CPU side.
   input  wire logic stop_mode,
   // Oscillation indication toward the device.
   output var  logic osc_running
);
   int cnt;
   // Rising-edge updates with non-blocking writes never race the falling-edge stimulus.
   // start-up delay
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 0;
         osc_running <= 1'b1;
      end else if (stop_mode) begin
         cnt <= 0;
         osc_running <= 1'b0;
      end else if (cnt < START_CYC) begin
         cnt <= cnt + 1;
      end else begin
         osc_running <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// ### tb.sv
// Self-checking testbench for the stabilization wait controller.
`timescale 1ns/1ps
`default_nettype none
module tb
   import osw_pkg::*;
;
   localparam int XD = 10;
   logic        clock = 1'b0;
   logic        rst_n = 1'b0;
   logic [15:0] mem_addr = 16'h0000;
   logic [7:0]  mem_wdata = 8'h00;
   logic        mem_wr = 1'b0;
   logic        mem_rd = 1'b0;
   logic        mem_bit_op = 1'b0;
   logic [7:0]  mem_rdata;
   logic        stop_mode = 1'b0;
   logic        cpu_clk_is_main = 1'b1;
   logic        osc_run;
   logic        cpu_hold;
   logic        stab_done;
   logic [4:0]  status;
   logic        ls_stop_allowed = 1'b0;
   logic        ls_stop_req = 1'b0;
   logic        ls_osc_run;
   logic        ls_tick;
   logic        ls_tick_div8;
   logic        ls_tick_div128;
   logic        ls_tick_div512;
   int          n_mismatch = 0;
   int          compares = 0;

   always #12.5 clock = ~clock;

   osw_xtal_model #(.START_CYC(XD)) xtal_u (.clock(clock), .rst_n(rst_n),
      .stop_mode(stop_mode), .osc_running(osc_run));

   osw_ctrl #(.WAIT_CNT_C1(17'h4), .WAIT_CNT_C2(17'h8), .WAIT_CNT_C3(17'hc),
      .WAIT_CNT_C4(17'h10), .WAIT_CNT_C5(17'h14)) dut_u (
      .clock(clock), .rst_n(rst_n), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_bit_op(mem_bit_op), .mem_rdata(mem_rdata),
      .stop_mode(stop_mode), .cpu_clk_is_main(cpu_clk_is_main),
      .main_crystal_osc_running(osc_run), .cpu_hold(cpu_hold), .stab_done(stab_done),
      .stabilization_status(status), .ls_stop_allowed(ls_stop_allowed),
      .ls_stop_req(ls_stop_req), .ls_osc_run(ls_osc_run), .ls_tick(ls_tick),
      .ls_tick_div8(ls_tick_div8), .ls_tick_div128(ls_tick_div128),
      .ls_tick_div512(ls_tick_div512));

   task automatic report_and_stop;
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One access; strobes stand for exactly one rising edge.
   task automatic bus(input logic [15:0] a, input logic [7:0] d, input logic wr,
                      input logic bop);
      @(negedge clock);
      mem_addr = a;
      mem_wdata = d;
      mem_wr = wr;
      mem_rd = ~wr;
      mem_bit_op = bop;
      @(negedge clock);
      mem_wr = 1'b0;
      mem_rd = 1'b0;
      mem_bit_op = 1'b0;
   endtask

   task automatic reset_values;
      bus(OFF_WAIT_SEL, 8'h00, 1'b0, 1'b0);
      check({24'h0, mem_rdata}, 32'h5);
      check({31'h0, cpu_hold}, 32'h0);
      check({31'h0, ls_osc_run}, 32'h1);
   endtask

   task automatic reg_access;
      bus(OFF_WAIT_SEL, 8'hff, 1'b1, 1'b0);
      bus(OFF_WAIT_SEL, 8'h00, 1'b0, 1'b0);
      check({24'h0, mem_rdata}, 32'h7);
      bus(OFF_WAIT_SEL, 8'h02, 1'b1, 1'b1);
      bus(OFF_WAIT_SEL, 8'h00, 1'b0, 1'b0);
      check({24'h0, mem_rdata}, 32'h7);
      bus(OFF_WAIT_SEL, 8'h03, 1'b1, 1'b0);
      bus(OFF_WAIT_SEL, 8'h00, 1'b0, 1'b1);
      check({24'h0, mem_rdata}, 32'h7);
      bus(16'hffb6, 8'h00, 1'b0, 1'b0);
      check({24'h0, mem_rdata}, 32'h7);
   endtask

   task automatic stop_cycle(input logic [2:0] code, input logic main, input int lim);
      int hold;
      int k;
      bus(OFF_WAIT_SEL, {5'h0, code}, 1'b1, 1'b0);
      cpu_clk_is_main = main;
      stop_mode = 1'b1;
      repeat (3) @(negedge clock);
      stop_mode = 1'b0;
      hold = 0;
      // select left alone during the wait
      for (k = 0; k < 300 && stab_done !== 1'b1; k++) begin
         @(negedge clock);
         if (cpu_hold === 1'b1)
            hold++;
      end
      if (k == 300) begin
         check({31'h0, stab_done}, 32'h1);
         report_and_stop();
      end
      check({27'h0, status}, (32'h1 << code) - 32'h1);
      if (main) begin
         check(32'(hold >= lim + XD), 32'h1);
         check(32'(hold <= lim + XD + 6), 32'h1);
      end else begin
         check(32'(hold), 32'h0);
      end
   endtask

   task automatic ls_check;
      int k;
      int n_t;
      int n_8;
      int n_128;
      int n_512;
      for (k = 0; k < 200 && ls_tick !== 1'b1; k++)
         @(negedge clock);
      if (k == 200) begin
         check({31'h0, ls_tick}, 32'h1);
         report_and_stop();
      end
      n_t = 0;
      n_8 = 0;
      n_128 = 0;
      n_512 = 0;
      for (k = 0; k < 128 * LS_DIV_CYC; k++) begin
         @(negedge clock);
         n_t += int'(ls_tick === 1'b1);
         n_8 += int'(ls_tick_div8 === 1'b1 && ls_tick === 1'b1);
         n_128 += int'(ls_tick_div128 === 1'b1 && ls_tick === 1'b1);
         n_512 += int'(ls_tick_div512 === 1'b1 && ls_tick_div128 !== 1'b1);
      end
      check(n_t, 32'd128);
      check(n_512, 32'd0);
      check(n_8, 32'd16);
      check(n_128, 32'd1);
      ls_stop_req = 1'b1;
      repeat (3) @(negedge clock);
      check({31'h0, ls_osc_run}, 32'h1);
      ls_stop_allowed = 1'b1;
      repeat (2) @(negedge clock);
      check({31'h0, ls_osc_run}, 32'h0);
      n_t = 0;
      repeat (400) begin
         @(negedge clock);
         n_t += int'(ls_tick === 1'b1);
      end
      check(n_t, 32'd0);
      ls_stop_req = 1'b0;
   endtask

   initial begin
      repeat (2) @(negedge clock);
      rst_n = 1'b1;
      reset_values();
      reg_access();
      stop_cycle(3'h5, 1'b1, 20);
      stop_cycle(3'h4, 1'b1, 16);
      stop_cycle(3'h3, 1'b1, 12);
      stop_cycle(3'h2, 1'b1, 8);
      stop_cycle(3'h1, 1'b1, 4);
      stop_cycle(3'h3, 1'b0, 12);
      ls_check();
      report_and_stop();
   end
endmodule
`default_nettype wire
